// ==== design/sdpr_regs.svh ====
`ifndef SDPR_REGS_SVH
`define SDPR_REGS_SVH
`define SDPR_ADDR_W 16
`define SDPR_DATA_W 8
`define SDPR_ADDR_ZERO 16'h0000
`define SDPR_REACT_CYCLES 2'h2
`endif

// ==== design/sdpr_pkg.sv ====
`default_nettype none
package sdpr_pkg;
	typedef struct packed {
		logic select_active_low;
		logic select_active_high;
		logic read_write;
		logic address_strobe;
		logic counter_advance;
		logic counter_clear;
	} sdpr_ctrl_t;
	typedef struct packed {
		logic sel;
		logic rd;
	} sdpr_stage_t;
endpackage : sdpr_pkg
`default_nettype wire

// ==== design/sdpr_port.sv ====
`include "sdpr_regs.svh"
`default_nettype none
module sdpr_port #(
	parameter int AW = `SDPR_ADDR_W,
	parameter int DW = `SDPR_DATA_W
) (
	input wire logic port_clk,
	input wire logic rst_n,
	input wire sdpr_pkg::sdpr_ctrl_t ctrl,
	input wire logic [AW-1:0] ext_addr,
	input wire logic [DW-1:0] din,
	input wire logic output_latency_select,
	input wire logic [DW-1:0] rd_word,
	output logic [AW-1:0] acc_addr,
	output logic acc_we,
	output logic [DW-1:0] acc_wdata,
	output logic [DW-1:0] dout,
	output logic drive,
	output logic standby
);
	import sdpr_pkg::*;
	sdpr_ctrl_t c_q;
	logic [AW-1:0] a_q, cnt_q, cnt_d;
	logic [DW-1:0] d_q, ft_q, pp_q;
	logic [1:0] act_q;
	sdpr_stage_t s1_q, s2_q;
	wire sel = !c_q.select_active_low && c_q.select_active_high;
	wire [AW-1:0] base = c_q.address_strobe ? cnt_q : a_q;
	// clear wins, then advance; strobe high and advance high holds
	assign acc_addr = !c_q.counter_clear ? AW'(0) :
		!c_q.counter_advance ? base + AW'(1) : base;
	assign cnt_d = acc_addr;
	// write lands in the array at the next edge, not within the cycle
	assign acc_we = sel && !c_q.read_write;
	assign acc_wdata = d_q;
	assign standby = !sel;
	wire react_ok = act_q >= `SDPR_REACT_CYCLES;
	assign dout = output_latency_select ? pp_q : ft_q;
	assign drive = output_latency_select ? (s2_q.sel && s2_q.rd && react_ok)
		: (s1_q.sel && s1_q.rd);
	always_ff @(posedge port_clk or negedge rst_n) begin
		if (!rst_n) begin
			c_q <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
			a_q <= '0;
			d_q <= '0;
			cnt_q <= '0;
			ft_q <= '0;
			pp_q <= '0;
			s1_q <= '0;
			s2_q <= '0;
			act_q <= '0;
		end else begin
			c_q <= ctrl;
			a_q <= ctrl.address_strobe ? a_q : ext_addr;
			d_q <= din;
			cnt_q <= cnt_d;
			ft_q <= sel ? rd_word : ft_q;
			pp_q <= ft_q;
			s1_q <= '{sel, c_q.read_write};
			s2_q <= s1_q;
			act_q <= !sel ? 2'h0 : react_ok ? act_q : act_q + 2'h1;
		end
	end
endmodule : sdpr_port
`default_nettype wire

// ==== design/sdpr_top.sv ====
// Behaviour
// - control, address and data inputs sampled on own port clock rising
// - deselect tristates outputs after next edge
// - strobe low loads address every edge
// - internal address: external or counter by strobe
// - no strobe, no advance: address holds
// - advance adds one, used same cycle
// - clear gives address zero, same cycle
// - output state from previous cycle controls
// - two identical independent ports
// - input registers update on rising edge
// - write lands in array at next rising edge
// - counter holds with neither advance nor strobe
// - deselect puts port in standby
// - pipelined outputs need two selected cycles
// - latency select high pipelined, low flow
`include "sdpr_regs.svh"
`default_nettype none
module sdpr_top #(
	parameter int AW = `SDPR_ADDR_W,
	parameter int DW = `SDPR_DATA_W
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_b,
	input wire sdpr_pkg::sdpr_ctrl_t ctrl_a,
	input wire logic [AW-1:0] addr_a,
	input wire logic [DW-1:0] din_a,
	input wire logic output_enable_n_a,
	input wire logic output_latency_select_a,
	output logic [DW-1:0] dout_a,
	output logic dout_oe_n_a,
	output logic standby_a,
	input wire sdpr_pkg::sdpr_ctrl_t ctrl_b,
	input wire logic [AW-1:0] addr_b,
	input wire logic [DW-1:0] din_b,
	input wire logic output_enable_n_b,
	input wire logic output_latency_select_b,
	output logic [DW-1:0] dout_b,
	output logic dout_oe_n_b,
	output logic standby_b
);
	import sdpr_pkg::*;
	////////////////////////////////////////////////////////////////////////
	logic [1:0] rst_a_q, rst_b_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_a_q <= 2'h0;
		end else begin
			rst_a_q <= {rst_a_q[0], 1'b1};
		end
	end
	always_ff @(posedge clk_b or negedge nrst) begin
		if (!nrst) begin
			rst_b_q <= 2'h0;
		end else begin
			rst_b_q <= {rst_b_q[0], 1'b1};
		end
	end
	////////////////////////////////////////////////////////////////////////
	// one array per writing port, so each array has a single clock and writer
	logic [DW-1:0] mem_a [0:(1<<AW)-1];
	logic [DW-1:0] mem_b [0:(1<<AW)-1];
	// tag pair per word: unequal tags mean port A wrote it last
	bit tag_a [0:(1<<AW)-1];
	bit tag_b [0:(1<<AW)-1];
	logic [AW-1:0] aa, ab;
	logic wa, wb, dra, drb;
	logic [DW-1:0] wda, wdb, ra, rb;
	function automatic logic [DW-1:0] newest_word(
		input bit ta,
		input bit tb,
		input logic [DW-1:0] word_a,
		input logic [DW-1:0] word_b
	);
		return (ta ^ tb) ? word_a : word_b;
	endfunction : newest_word
	assign ra = newest_word(tag_a[aa], tag_b[aa], mem_a[aa], mem_b[aa]);
	assign rb = newest_word(tag_a[ab], tag_b[ab], mem_a[ab], mem_b[ab]);
	// each port writes on its own clock; same-word collision is host's care
	always_ff @(posedge core_clk) begin
		if (wa) begin
			mem_a[aa] <= wda;
			tag_a[aa] <= !tag_b[aa];
		end
	end
	always_ff @(posedge clk_b) begin
		if (wb) begin
			mem_b[ab] <= wdb;
			tag_b[ab] <= tag_a[ab];
		end
	end
	////////////////////////////////////////////////////////////////////////
	sdpr_port #(.AW(AW), .DW(DW)) u_port_a (
		.port_clk(core_clk),
		.rst_n(rst_a_q[1]),
		.ctrl(ctrl_a),
		.ext_addr(addr_a),
		.din(din_a),
		.output_latency_select(output_latency_select_a),
		.rd_word(ra),
		.acc_addr(aa),
		.acc_we(wa),
		.acc_wdata(wda),
		.dout(dout_a),
		.drive(dra),
		.standby(standby_a)
	);
	sdpr_port #(.AW(AW), .DW(DW)) u_port_b (
		.port_clk(clk_b),
		.rst_n(rst_b_q[1]),
		.ctrl(ctrl_b),
		.ext_addr(addr_b),
		.din(din_b),
		.output_latency_select(output_latency_select_b),
		.rd_word(rb),
		.acc_addr(ab),
		.acc_we(wb),
		.acc_wdata(wdb),
		.dout(dout_b),
		.drive(drb),
		.standby(standby_b)
	);
	// output enable is asynchronous
	assign dout_oe_n_a = !(dra && !output_enable_n_a);
	assign dout_oe_n_b = !(drb && !output_enable_n_b);
endmodule : sdpr_top
`default_nettype wire

// ==== verification/sdpr_host_b.sv ====
`default_nettype none
module sdpr_host_b (
	input wire logic clk_b,
	output var sdpr_pkg::sdpr_ctrl_t ctrl_b,
	output logic [15:0] addr_b,
	output logic [7:0] din_b
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ctrl_b = 6'h2F;
		addr_b = 16'h55;
		din_b = 8'hC3;
		repeat (6) @(negedge clk_b);
		ctrl_b = 6'h1B;
		@(negedge clk_b);
		ctrl_b = 6'h2F;
		@(negedge clk_b);
		ctrl_b = 6'h13;
		@(negedge clk_b);
		ctrl_b = 6'h1B;
		din_b = ~din_b;
		@(negedge clk_b);
		ctrl_b = 6'h2F;
	end
endmodule : sdpr_host_b
`default_nettype wire

// ==== verification/sdpr_assertions.sv ====
`default_nettype none
module sdpr_chk (
	input wire logic core_clk,
	input wire logic nrst,
	input wire sdpr_pkg::sdpr_ctrl_t ctrl_a,
	input wire logic output_enable_n_a,
	input wire logic output_latency_select_a,
	input wire logic [7:0] dout_a,
	input wire logic dout_oe_n_a,
	input wire logic standby_a
);
	import sdpr_pkg::*;
	wire off = dout_oe_n_a;
	wire pl = output_latency_select_a;
	wire s = !ctrl_a.select_active_low && ctrl_a.select_active_high;
	wire rd = s && ctrl_a.read_write;
	wire wr = s && !ctrl_a.read_write;
	wire hd = rd && ctrl_a[2:0] == 3'h7;
	wire ok = output_enable_n_a || !off;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_oe_off: assert property (output_enable_n_a |-> off)
		else $error("drives while disabled");
	a_desel_hiz: assert property (!s ##1 !s |-> ##1 off)
		else $error("drives deselected");
	a_desel_standby: assert property (!s |=> standby_a)
		else $error("no standby");
	a_pipe_two_sel: assert property (pl && !s ##1 s |-> ##1 off)
		else $error("early reactivation");
	a_hold_data: assert property (!pl && hd ##1 hd |-> ##2 $stable(dout_a))
		else $error("held data moved");
	a_flow_read: assert property (!pl && rd |-> ##2 ok)
		else $error("flow read idle");
	a_pipe_read: assert property (pl && rd [*3] |-> ##3 ok)
		else $error("pipe read idle");
	a_write_hiz: assert property (!pl && wr |-> ##2 off)
		else $error("drives after write");
	c_pipe: cover property (pl && rd [*3]);
	c_hold: cover property (!pl && hd ##1 hd);
	c_wake: cover property (!s ##1 !s ##1 s);
endmodule : sdpr_chk
bind sdpr_top sdpr_chk u_chk (.*);
`default_nettype wire

// ==== verification/tb_sync_dual_port_ram_port.sv ====
`default_nettype none
module tb_sync_dual_port_ram_port;
	timeunit 1ns;
	timeprecision 1ps;
	import sdpr_pkg::*;
	logic core_clk = 0, nrst = 0, dout_oe_n_a, dout_oe_n_b, standby_a;
	logic output_enable_n_a = 0, output_latency_select_a = 0, standby_b;
	logic output_enable_n_b = 1, output_latency_select_b = 0;
	wire clk_b = core_clk;
	sdpr_ctrl_t ctrl_a = 6'h2F, ctrl_b;
	logic [15:0] addr_a = 0, addr_b;
	logic [7:0] din_a = 0, din_b, dout_a, dout_b;
	int error_cnt = 0, checks_done = 0, cycles = 0;
	sdpr_host_b host (.*);
	sdpr_top dut (.*);
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 300) begin
			error_cnt++;
			stop_test;
		end
	end
	task automatic chk(input logic [7:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %0t: %h not %h", $time, got, exp);
		end
	endtask : chk
	// one access, then held reads until the answer is due
	task automatic go(input logic [5:0] c, input logic [15:0] a);
		@(negedge core_clk);
		ctrl_a = c;
		addr_a = a;
		din_a = a[15:8] ^ c;
		@(negedge core_clk);
		ctrl_a = 6'h1F;
		repeat (output_latency_select_a + 1) @(posedge core_clk);
		#1;
	endtask : go
	task automatic t_access;
		go(6'h13, 16'hA510);
		go(6'h15, 16'h5A00);
		go(6'h16, 16'h3C00);
		go(6'h1B, 16'hA510);
		chk(dout_a, 8'hB6);
		go(6'h1D, 16'h0000);
		chk(dout_a, 8'h4F);
		go(6'h1E, 16'h0000);
		chk(dout_a, 8'h2A);
		go(6'h1B, 16'h0055);
		chk(dout_a, 8'hC3);
	endtask : t_access
	task automatic t_port_b;
		chk(dout_b, 8'hC3);
		chk(8'({dout_oe_n_b, standby_b}), 8'h03);
	endtask : t_port_b
	task automatic t_pipe;
		repeat (2) @(negedge core_clk);
		ctrl_a = 6'h2F;
		repeat (2) @(posedge core_clk);
		#1;
		chk(8'({dout_oe_n_a, standby_a}), 8'h03);
		@(negedge core_clk);
		ctrl_a = 6'h1F;
		@(negedge core_clk);
		ctrl_a = 6'h0F;
		repeat (2) @(posedge core_clk);
		#1;
		chk(8'({dout_oe_n_a, standby_a}), 8'h03);
		@(negedge core_clk);
		nrst = 0;
		output_latency_select_a = 1;
		repeat (3) @(negedge core_clk);
		nrst = 1;
		repeat (3) @(negedge core_clk);
		go(6'h1B, 16'hA510);
		chk(dout_a, 8'hB6);
		chk(8'(dout_oe_n_a), 8'h00);
		@(negedge core_clk);
		output_enable_n_a = 1;
		#1;
		chk(8'(dout_oe_n_a), 8'h01);
		@(negedge core_clk);
		output_enable_n_a = 0;
		repeat (4) @(negedge core_clk);
	endtask : t_pipe
	task automatic stop_test;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	initial begin
		repeat (3) @(negedge core_clk);
		nrst = 1;
		repeat (3) @(negedge core_clk);
		t_access;
		t_port_b;
		t_pipe;
		stop_test;
	end
endmodule : tb_sync_dual_port_ram_port
`default_nettype wire
